//--- hjps_pkg.sv
// Package of shared constants for the shared host/test serial port
package hjps_pkg;
  // Serial word width on the host serial port
  localparam int unsigned WORD_W       = 16;
  // Bit counter width
  localparam int unsigned CNT_W        = 5;
  // Host clock divider: half period of link clock in core cycles
  localparam int unsigned SCLK_HALF    = 8;
  localparam logic [7:0]  SCLK_HALF_C  = 8'h08;
  // Test instruction register width
  localparam int unsigned IR_W         = 4;
  // Reset value of the device status word
  localparam logic [15:0] STATUS_RST   = 16'h0000;
  // Reset value of configuration word
  localparam logic [15:0] CONFIG_RST   = 16'h0000;
  // Identification value returned in test mode, arbitrary value
  localparam logic [31:0] TEST_IDCODE  = 32'h1234_5671;
  // Test state encodings
  typedef enum logic [3:0] {
    TAP_RESET  = 4'h0,
    TAP_IDLE   = 4'h1,
    TAP_SELDR  = 4'h2,
    TAP_CAPDR  = 4'h3,
    TAP_SHDR   = 4'h4,
    TAP_EX1DR  = 4'h5,
    TAP_PAUSDR = 4'h6,
    TAP_EX2DR  = 4'h7,
    TAP_UPDDR  = 4'h8,
    TAP_SELIR  = 4'h9,
    TAP_CAPIR  = 4'hA,
    TAP_SHIR   = 4'hB,
    TAP_EX1IR  = 4'hC,
    TAP_PAUSIR = 4'hD,
    TAP_EX2IR  = 4'hE,
    TAP_UPDIR  = 4'hF
  } hjps_tap_e;
endpackage

//--- hjps_link_if.sv
// Interface joining the device end and the host/test controller end
`timescale 1ns/1ps
interface hjps_link_if;
  logic serialClk;         // Bit clock, driven by the controller
  logic selectN;           // Chip select (host) or mode select line (test)
  logic sharedSerialIn;    // Controller to device data
  logic sharedSerialOut;   // Device to controller data value
  logic sharedSerialOutOe; // Device output enable
  logic portSelect;        // High selects test mode
  logic resetN;            // Active-low reset pin
  logic lineSwitchLockEnable; // Switch-line locking enable pin
  modport device (input serialClk, selectN, sharedSerialIn, portSelect, resetN, lineSwitchLockEnable,
                  output sharedSerialOut, sharedSerialOutOe);
  modport host (output serialClk, selectN, sharedSerialIn, portSelect, resetN, lineSwitchLockEnable,
                input sharedSerialOut, sharedSerialOutOe);
endinterface

//--- hjps_sync2.sv
// Two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module hjps_sync2 #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  // Asynchronous levels in, synchronised out
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] stage1_r; // First stage, read only by second stage
  logic [W-1:0] stage2_r; // Second stage
  // Register both stages
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stage1_r <= '0;
      stage2_r <= '0;
    end else begin
      stage1_r <= asyncIn;
      stage2_r <= stage1_r;
    end
  end
  assign syncOut = stage2_r;
endmodule

//--- hjps_device.sv
// Device end: shared host serial / test access port with reset handling
// Notes on behaviour
// - Host mode reset low: defaults, outputs released
// - Host mode reset high: normal operation resumes
// - Test mode reset low: defaults, test sequence reset
// - Test sequence resumes only after reset release
// - Select high: shared pins become test port
// - Select low: shared pins are host port
// - Test mode: output pin carries test data out
// - Host mode: output pin returns read data
// - Test mode: controller supplies test data in
// - Host mode: host sends address then data
// - Test mode: select pin is mode select
// - Host mode: select pin is active-low chip select
// - Test mode: clock pin is test clock
// - All bits move with external bit clock
// - Switch-line locking follows its enable input while reset pin is high, forced off while it is low
`timescale 1ns/1ps
module hjps_device (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Link to controller
  hjps_link_if.device      link,
  // User side
  output logic             functionalActive, // Blocks out of default state
  output logic             testMode,         // Port in test role
  output logic             lineSwitchLock,   // Switch-line locking enabled
  output logic [15:0]      configWord,       // Last written configuration word
  output logic [15:0]      configAddr,       // Address word of last access, read or write
  output logic             configStrobe,     // One-cycle pulse on a write
  input  wire logic [15:0] statusWord        // Status returned on reads
);
  // Synchronised pins: clk, sel, din, mode, rstn, swen
  logic [5:0] pinSync;
  logic sclkS, selS, dinS, modeS, rstnS, swenS;
  hjps_sync2 #(.W(6)) uSync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .asyncIn  ({link.serialClk, link.selectN, link.sharedSerialIn, link.portSelect, link.resetN,
                link.lineSwitchLockEnable}),
    .syncOut  (pinSync)
  );
  assign {sclkS, selS, dinS, modeS, rstnS, swenS} = pinSync;

  // State registers
  logic                 sclkPrev_r, sclkPrev_nxt;  // Previous clock level for edge detect
  logic                 inReset_r, inReset_nxt;    // Blocks held at default
  logic                 active_r, active_nxt;      // Blocks out of default state
  logic                 mode_r, mode_nxt;          // Port role
  logic                 swen_r, swen_nxt;          // Switch-line lock
  logic [4:0]           bitCnt_r, bitCnt_nxt;      // Bits of current word
  logic                 haveAddr_r, haveAddr_nxt;  // Address word received
  logic                 rdCmd_r, rdCmd_nxt;        // Current access is a read
  logic [15:0]          shIn_r, shIn_nxt;          // Input shift register
  logic [15:0]          shOut_r, shOut_nxt;        // Output shift register
  logic [15:0]          addr_r, addr_nxt;          // Captured address
  logic [15:0]          cfg_r, cfg_nxt;            // Configuration word
  logic                 strobe_r, strobe_nxt;      // Write pulse
  logic                 sdo_r, sdo_nxt;            // Output pin value
  logic                 oe_r, oe_nxt;              // Output pin enable
  hjps_pkg::hjps_tap_e  tap_r, tap_nxt;            // Test state
  logic [3:0]           ir_r, ir_nxt;              // Instruction register
  logic [31:0]          dr_r, dr_nxt;              // Data register
  logic                 rise, fall;                // Clock edges
  logic                 tms;                       // Select pin as mode select

  assign rise = sclkS & ~sclkPrev_r;
  assign fall = ~sclkS & sclkPrev_r;
  assign tms  = selS;

  // Next-state logic for both port roles
  always_comb begin
    sclkPrev_nxt = sclkS;
    inReset_nxt  = ~rstnS;
    active_nxt   = rstnS;
    mode_nxt     = modeS;
    swen_nxt     = swenS & rstnS;
    bitCnt_nxt   = bitCnt_r;
    haveAddr_nxt = haveAddr_r;
    rdCmd_nxt    = rdCmd_r;
    shIn_nxt     = shIn_r;
    shOut_nxt    = shOut_r;
    addr_nxt     = addr_r;
    cfg_nxt      = cfg_r;
    strobe_nxt   = 1'b0;
    sdo_nxt      = sdo_r;
    oe_nxt       = 1'b0;
    tap_nxt      = tap_r;
    ir_nxt       = ir_r;
    dr_nxt       = dr_r;
    if (inReset_r) begin
      // Defaults everywhere, output released
      bitCnt_nxt   = '0;
      haveAddr_nxt = 1'b0;
      rdCmd_nxt    = 1'b0;
      shIn_nxt     = '0;
      shOut_nxt    = '0;
      addr_nxt     = '0;
      cfg_nxt      = hjps_pkg::CONFIG_RST;
      sdo_nxt      = 1'b0;
      tap_nxt      = hjps_pkg::TAP_RESET;
      ir_nxt       = '0;
      dr_nxt       = '0;
    end else if (mode_r) begin
      // Test role
      oe_nxt = 1'b1;
      if (rise) begin
        case (tap_r)
          hjps_pkg::TAP_RESET:  tap_nxt = tms ? hjps_pkg::TAP_RESET : hjps_pkg::TAP_IDLE;
          hjps_pkg::TAP_IDLE:   tap_nxt = tms ? hjps_pkg::TAP_SELDR : hjps_pkg::TAP_IDLE;
          hjps_pkg::TAP_SELDR:  tap_nxt = tms ? hjps_pkg::TAP_SELIR : hjps_pkg::TAP_CAPDR;
          hjps_pkg::TAP_CAPDR: begin
            dr_nxt  = (ir_r == '0) ? hjps_pkg::TEST_IDCODE : {16'h0000, cfg_r};
            tap_nxt = tms ? hjps_pkg::TAP_EX1DR : hjps_pkg::TAP_SHDR;
          end
          hjps_pkg::TAP_SHDR: begin
            dr_nxt  = {dinS, dr_r[31:1]};
            tap_nxt = tms ? hjps_pkg::TAP_EX1DR : hjps_pkg::TAP_SHDR;
          end
          hjps_pkg::TAP_EX1DR:  tap_nxt = tms ? hjps_pkg::TAP_UPDDR : hjps_pkg::TAP_PAUSDR;
          hjps_pkg::TAP_PAUSDR: tap_nxt = tms ? hjps_pkg::TAP_EX2DR : hjps_pkg::TAP_PAUSDR;
          hjps_pkg::TAP_EX2DR:  tap_nxt = tms ? hjps_pkg::TAP_UPDDR : hjps_pkg::TAP_SHDR;
          hjps_pkg::TAP_UPDDR:  tap_nxt = tms ? hjps_pkg::TAP_SELDR : hjps_pkg::TAP_IDLE;
          hjps_pkg::TAP_SELIR:  tap_nxt = tms ? hjps_pkg::TAP_RESET : hjps_pkg::TAP_CAPIR;
          hjps_pkg::TAP_CAPIR: begin
            dr_nxt  = 32'h0000_0001;
            tap_nxt = tms ? hjps_pkg::TAP_EX1IR : hjps_pkg::TAP_SHIR;
          end
          hjps_pkg::TAP_SHIR: begin
            dr_nxt  = {28'h0000000, dinS, dr_r[3:1]};
            tap_nxt = tms ? hjps_pkg::TAP_EX1IR : hjps_pkg::TAP_SHIR;
          end
          hjps_pkg::TAP_EX1IR:  tap_nxt = tms ? hjps_pkg::TAP_UPDIR : hjps_pkg::TAP_PAUSIR;
          hjps_pkg::TAP_PAUSIR: tap_nxt = tms ? hjps_pkg::TAP_EX2IR : hjps_pkg::TAP_PAUSIR;
          hjps_pkg::TAP_EX2IR:  tap_nxt = tms ? hjps_pkg::TAP_UPDIR : hjps_pkg::TAP_SHIR;
          hjps_pkg::TAP_UPDIR: begin
            ir_nxt  = dr_r[3:0];
            tap_nxt = tms ? hjps_pkg::TAP_SELDR : hjps_pkg::TAP_IDLE;
          end
          default:              tap_nxt = hjps_pkg::TAP_RESET;
        endcase
      end
      if (fall) begin
        sdo_nxt = dr_r[0];
      end
    end else begin
      // Host role: select low frames an access
      tap_nxt = hjps_pkg::TAP_RESET;
      if (selS) begin
        bitCnt_nxt   = '0;
        haveAddr_nxt = 1'b0;
        rdCmd_nxt    = 1'b0;
      end else begin
        oe_nxt = rdCmd_r & haveAddr_r;
        if (rise) begin
          shIn_nxt = {shIn_r[14:0], dinS};
          if (bitCnt_r == 5'h0F) begin
            bitCnt_nxt = '0;
            if (!haveAddr_r) begin
              // Address word: MSB flags read
              addr_nxt     = {shIn_r[14:0], dinS};
              rdCmd_nxt    = shIn_r[14];
              haveAddr_nxt = 1'b1;
              shOut_nxt    = statusWord;
            end else if (!rdCmd_r) begin
              cfg_nxt    = {shIn_r[14:0], dinS};
              strobe_nxt = 1'b1;
            end else begin
              shOut_nxt = statusWord;
            end
          end else begin
            bitCnt_nxt = bitCnt_r + 5'h01;
          end
        end
        if (fall && haveAddr_r && rdCmd_r) begin
          sdo_nxt   = shOut_r[15];
          shOut_nxt = {shOut_r[14:0], 1'b0};
        end
      end
    end
  end

  // Register all state
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sclkPrev_r <= 1'b0;
      inReset_r  <= 1'b1;
      active_r   <= 1'b0;
      mode_r     <= 1'b0;
      swen_r     <= 1'b0;
      bitCnt_r   <= '0;
      haveAddr_r <= 1'b0;
      rdCmd_r    <= 1'b0;
      shIn_r     <= '0;
      shOut_r    <= '0;
      addr_r     <= '0;
      cfg_r      <= hjps_pkg::CONFIG_RST;
      strobe_r   <= 1'b0;
      sdo_r      <= 1'b0;
      oe_r       <= 1'b0;
      tap_r      <= hjps_pkg::TAP_RESET;
      ir_r       <= '0;
      dr_r       <= '0;
    end else begin
      sclkPrev_r <= sclkPrev_nxt;
      inReset_r  <= inReset_nxt;
      active_r   <= active_nxt;
      mode_r     <= mode_nxt;
      swen_r     <= swen_nxt;
      bitCnt_r   <= bitCnt_nxt;
      haveAddr_r <= haveAddr_nxt;
      rdCmd_r    <= rdCmd_nxt;
      shIn_r     <= shIn_nxt;
      shOut_r    <= shOut_nxt;
      addr_r     <= addr_nxt;
      cfg_r      <= cfg_nxt;
      strobe_r   <= strobe_nxt;
      sdo_r      <= sdo_nxt;
      oe_r       <= oe_nxt;
      tap_r      <= tap_nxt;
      ir_r       <= ir_nxt;
      dr_r       <= dr_nxt;
    end
  end

  // Outputs straight from flops
  assign link.sharedSerialOut   = sdo_r;
  assign link.sharedSerialOutOe = oe_r;
  assign functionalActive       = active_r;
  assign testMode               = mode_r;
  assign lineSwitchLock         = swen_r;
  assign configWord             = cfg_r;
  assign configAddr             = addr_r;
  assign configStrobe           = strobe_r;
endmodule

//--- hjps_host.sv
// Controller end: host serial master driving the shared port
`timescale 1ns/1ps
module hjps_host (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Link to device
  hjps_link_if.host        link,
  // User command port
  input  wire logic        cmdValid,   // Start a 32-bit host access
  input  wire logic        cmdRead,    // Access is a read
  input  wire logic [14:0] cmdAddr,    // Address
  input  wire logic [15:0] cmdData,    // Write data
  input  wire logic        testSelect, // Level for port select pin
  input  wire logic        devResetN,  // Level for device reset pin
  input  wire logic        swLockEn,   // Level for switch-line enable pin
  output logic             busy,       // Access in progress
  output logic             done,       // One-cycle pulse at end
  output logic [15:0]      rdData      // Read result
);
  // Divider and shift state
  logic [7:0]  div_r, div_nxt;     // Half-period counter
  logic        sclk_r, sclk_nxt;   // Bit clock
  logic        cs_r, cs_nxt;       // Active-low select
  logic [31:0] sh_r, sh_nxt;       // Outgoing bits
  logic [5:0]  cnt_r, cnt_nxt;     // Bits remaining
  logic        busy_r, busy_nxt;
  logic        done_r, done_nxt;
  logic [15:0] rd_r, rd_nxt;
  logic        din_r, din_nxt;
  logic        sdoS;               // Synchronised device data

  hjps_sync2 #(.W(1)) uSync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .asyncIn  (link.sharedSerialOut),
    .syncOut  (sdoS)
  );

  // Next-state: drive data on falling edge, device samples on rise
  always_comb begin
    div_nxt  = div_r;
    sclk_nxt = sclk_r;
    cs_nxt   = cs_r;
    sh_nxt   = sh_r;
    cnt_nxt  = cnt_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    rd_nxt   = rd_r;
    din_nxt  = din_r;
    if (!busy_r) begin
      if (cmdValid) begin
        busy_nxt = 1'b1;
        // Host role frames with select low; test role puts the first stream bit on mode select
        cs_nxt   = testSelect ? cmdRead : 1'b0;
        sh_nxt   = {cmdRead, cmdAddr, cmdData};
        cnt_nxt  = 6'h20;
        div_nxt  = '0;
        din_nxt  = cmdRead;
      end
    end else if (div_r == hjps_pkg::SCLK_HALF_C - 8'h01) begin
      div_nxt = '0;
      if (!sclk_r) begin
        sclk_nxt = 1'b1;
        rd_nxt   = {rd_r[14:0], sdoS};
        cnt_nxt  = cnt_r - 6'h01;
      end else begin
        sclk_nxt = 1'b0;
        sh_nxt   = {sh_r[30:0], 1'b0};
        din_nxt  = sh_r[30];
        if (testSelect) begin
          // Test role: the same stream steers the mode select line, so a command can walk the test states
          cs_nxt = sh_r[30];
        end
        // Frame end wins over the stream and releases the select line
        if (cnt_r == 6'h00) begin
          busy_nxt = 1'b0;
          cs_nxt   = 1'b1;
          done_nxt = 1'b1;
        end
      end
    end else begin
      div_nxt = div_r + 8'h01;
    end
  end

  // Register state
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      div_r  <= '0;
      sclk_r <= 1'b0;
      cs_r   <= 1'b1;
      sh_r   <= '0;
      cnt_r  <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      rd_r   <= '0;
      din_r  <= 1'b0;
    end else begin
      div_r  <= div_nxt;
      sclk_r <= sclk_nxt;
      cs_r   <= cs_nxt;
      sh_r   <= sh_nxt;
      cnt_r  <= cnt_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      rd_r   <= rd_nxt;
      din_r  <= din_nxt;
    end
  end

  assign link.serialClk            = sclk_r;
  assign link.selectN              = cs_r;
  assign link.sharedSerialIn       = din_r;
  assign link.portSelect           = testSelect;
  assign link.resetN               = devResetN;
  assign link.lineSwitchLockEnable = swLockEn;
  assign busy                      = busy_r;
  assign done                      = done_r;
  assign rdData                    = rd_r;
endmodule

//--- hjps_link_sva.sv
// Checker of the shared serial link between the device end and the controller end
`timescale 1ns/1ps
module hjps_link_sva (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Link signals
  input wire logic serialClk,
  input wire logic selectN,
  input wire logic sharedSerialIn,
  input wire logic sharedSerialOut,
  input wire logic sharedSerialOutOe,
  input wire logic portSelect,
  input wire logic resetN,
  input wire logic lineSwitchLockEnable
);
  logic [5:0] riseCnt_r;   // Bit clock rises seen in the current frame
  logic [5:0] riseCnt_nxt; // Next frame count
  logic       clkPrev_r;   // Bit clock one cycle back
  // Count rises while selected; a deselect clears the count
  always_comb begin
    riseCnt_nxt = riseCnt_r + {5'h00, serialClk & ~clkPrev_r};
    if (selectN) begin
      riseCnt_nxt = 6'h00;
    end
  end
  // Register the frame count and the clock history
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      riseCnt_r <= 6'h00;
      clkPrev_r <= 1'b0;
    end else begin
      riseCnt_r <= riseCnt_nxt;
      clkPrev_r <= serialClk;
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // Reset pin low releases the output pin, whatever the mode
  reset_release_a: assert property (!resetN [*5] |-> !sharedSerialOutOe)
    else $error("output enable high while reset pin held low");
  // Deselected host port leaves the output pin undriven
  host_idle_off_a: assert property ((!portSelect && resetN && selectN) [*6] |-> !sharedSerialOutOe)
    else $error("output driven while host port deselected");
  // Test role keeps the output pin driven
  test_drive_a: assert property ((portSelect && resetN) [*6] |-> sharedSerialOutOe)
    else $error("output not driven in test role");
  // Bit clock rests low between host frames; in the test role the line is a mode select
  clock_idle_a: assert property (!portSelect && selectN |-> !serialClk)
    else $error("bit clock high outside a frame");
  // Each bit clock high phase lasts exactly eight core cycles
  half_period_a: assert property ($rose(serialClk) |-> serialClk [*8] ##1 !serialClk)
    else $error("bit clock high phase not eight cycles");
  // Data in holds still while the bit clock is high
  din_hold_a: assert property (!selectN && serialClk && $past(serialClk) |-> $stable(sharedSerialIn))
    else $error("data in changed while bit clock high");
  // Data out moves only while the bit clock is low
  dout_move_a: assert property (resetN && $past(resetN) && sharedSerialOutOe && $past(sharedSerialOutOe)
                                && !$stable(sharedSerialOut) |-> !serialClk)
    else $error("data out changed while bit clock high");
  // A host frame is an address word and a data word
  frame_len_a: assert property (!portSelect && $rose(selectN) |-> riseCnt_r == 6'h20)
    else $error("frame did not carry thirty-two bits");
  // Main scenarios
  frame_c: cover property ($rose(selectN));
  test_c: cover property (portSelect && sharedSerialOutOe);
  lock_rst_c: cover property (lineSwitchLockEnable && !resetN);
endmodule

//--- tb_host_jtag_port_select_reset.sv
// Testbench joining the device end and the controller end over the shared link
`timescale 1ns/1ps
module tb_host_jtag_port_select_reset;
  logic        core_clk;         // Core clock
  logic        sys_rst;          // Synchronous reset
  logic        functionalActive; // Device out of defaults
  logic        testMode;         // Device in test role
  logic        lineSwitchLock;   // Switch-line locking state
  logic [15:0] configWord;       // Last written word
  logic [15:0] configAddr;       // Last accessed address word
  logic        configStrobe;     // Write pulse
  logic [15:0] statusWord;       // Status returned on reads
  logic        cmdValid;         // Command request
  logic        cmdRead;          // Command is a read
  logic [14:0] cmdAddr;          // Command address
  logic [15:0] cmdData;          // Command write data
  logic        testSelect;       // Port select level
  logic        devResetN;        // Device reset level
  logic        swLockEn;         // Switch-line enable level
  logic        busy;             // Access in progress
  logic        done;             // Access finished
  logic [15:0] rdData;           // Read result
  int          bad_count;        // Mismatches
  int          num_checks;       // Comparisons
  int          strobes;          // Write pulses seen
  int          s0;               // Pulse count snapshot
  int          k;                // Loop index
  logic [15:0] idExp;            // Expected test data out word
  hjps_link_if link();
  // Clock at 200 MHz
  always #2.5 core_clk = ~core_clk;
  // Count write pulses from the device
  always @(posedge core_clk) begin
    if (configStrobe === 1'b1) begin
      strobes++;
    end
  end
  hjps_device u_hjps_device (.core_clk(core_clk), .sys_rst(sys_rst), .link(link.device),
    .functionalActive(functionalActive), .testMode(testMode), .lineSwitchLock(lineSwitchLock),
    .configWord(configWord), .configAddr(configAddr), .configStrobe(configStrobe), .statusWord(statusWord));
  hjps_host u_hjps_host (.core_clk(core_clk), .sys_rst(sys_rst), .link(link.host), .cmdValid(cmdValid),
    .cmdRead(cmdRead), .cmdAddr(cmdAddr), .cmdData(cmdData), .testSelect(testSelect), .devResetN(devResetN),
    .swLockEn(swLockEn), .busy(busy), .done(done), .rdData(rdData));
  hjps_link_sva u_hjps_link_sva (.core_clk(core_clk), .sys_rst(sys_rst), .serialClk(link.serialClk),
    .selectN(link.selectN), .sharedSerialIn(link.sharedSerialIn), .sharedSerialOut(link.sharedSerialOut),
    .sharedSerialOutOe(link.sharedSerialOutOe), .portSelect(link.portSelect), .resetN(link.resetN),
    .lineSwitchLockEnable(link.lineSwitchLockEnable));
  // Print the counts and the verdict, then stop
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Compare a 16-bit value
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Compare a single bit
  task automatic chkb(input string what, input logic exp, input logic got);
    chk(what, {15'h0000, exp}, {15'h0000, got});
  endtask
  // Let n edges pass, then settle just after the last
  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // One host access, waited for under a bound
  task automatic access(input logic rd, input logic [14:0] addr, input logic [15:0] data);
    int i;
    cmdRead = rd;
    cmdAddr = addr;
    cmdData = data;
    cmdValid = 1'b1;
    cycles(1);
    cmdValid = 1'b0;
    chkb("busy", 1'b1, busy);
    for (i = 0; i < 1000 && done !== 1'b1; i++) begin
      cycles(1);
    end
    if (done !== 1'b1) begin
      bad_count++;
      $display("[ERR] done expected 1 seen %b", done);
      wrap_up();
    end
    chkb("busy", 1'b0, busy);
    cycles(2);
  endtask
  // Main sequence
  initial begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    {cmdValid, cmdRead, cmdAddr, cmdData} = '0;
    {testSelect, swLockEn, statusWord} = '0;
    devResetN = 1'b1;
    bad_count = 0;
    num_checks = 0;
    strobes = 0;
    cycles(3);
    sys_rst = 1'b0;
    cycles(6);
    chkb("active", 1'b1, functionalActive);
    // Back-to-back writes, top address last
    s0 = strobes;
    access(1'b0, 15'h0012, 16'hA5C3);
    chk("cfgWord", 16'hA5C3, configWord);
    chk("cfgAddr", 16'h0012, configAddr);
    access(1'b0, 15'h7FFF, 16'h5A3C);
    chk("cfgWord", 16'h5A3C, configWord);
    chk("cfgAddr", 16'h7FFF, configAddr);
    chk("strobes", 16'(s0 + 2), 16'(strobes));
    // Read returns the status word
    statusWord = 16'hBEEF;
    access(1'b1, 15'h0034, 16'h0000);
    chk("rdData", 16'hBEEF, rdData);
    chk("cfgAddr", 16'h8034, configAddr);
    // Switch-line locking follows its enable
    swLockEn = 1'b1;
    cycles(6);
    chkb("lock", 1'b1, lineSwitchLock);
    // Reset pin low in host mode: defaults, output released, writes ignored
    devResetN = 1'b0;
    cycles(6);
    chkb("active", 1'b0, functionalActive);
    chkb("oe", 1'b0, link.sharedSerialOutOe);
    chkb("lock", 1'b0, lineSwitchLock);
    chk("cfgWord", hjps_pkg::CONFIG_RST, configWord);
    s0 = strobes;
    access(1'b0, 15'h0001, 16'h1111);
    chk("strobes", 16'(s0), 16'(strobes));
    devResetN = 1'b1;
    cycles(1);
    chkb("active", 1'b0, functionalActive);
    cycles(6);
    chkb("active", 1'b1, functionalActive);
    swLockEn = 1'b0;
    cycles(6);
    chkb("lock", 1'b0, lineSwitchLock);
    // Test role: pins reassigned, host frames ignored
    testSelect = 1'b1;
    cycles(6);
    chkb("testMode", 1'b1, testMode);
    chkb("oe", 1'b1, link.sharedSerialOutOe);
    s0 = strobes;
    access(1'b0, 15'h0002, 16'h2222);
    chk("strobes", 16'(s0), 16'(strobes));
    chk("cfgWord", hjps_pkg::CONFIG_RST, configWord);
    // Reset pin low in test role
    devResetN = 1'b0;
    cycles(6);
    chkb("oe", 1'b0, link.sharedSerialOutOe);
    chkb("active", 1'b0, functionalActive);
    devResetN = 1'b1;
    cycles(8);
    chkb("oe", 1'b1, link.sharedSerialOutOe);
    // Mode select 0,1,0,0 walks reset, idle, select, capture into shift; the id word leaves LSB first,
    // rises 5 to 32 sample bits 0 to 27, so the last sixteen held are bits 12 to 27, bit 12 highest
    access(1'b0, 15'h4000, 16'h0000);
    for (k = 0; k < 16; k++) begin
      idExp[15 - k] = hjps_pkg::TEST_IDCODE[12 + k];
    end
    chk("tdo", idExp, rdData);
    // Back to host role: writes land again
    testSelect = 1'b0;
    cycles(6);
    chkb("testMode", 1'b0, testMode);
    access(1'b0, 15'h0003, 16'h3C3C);
    chk("cfgWord", 16'h3C3C, configWord);
    wrap_up();
  end
endmodule
